// File: rtl/rbs_pkg.sv
// Notes on behaviour
// - Any reset source holds the device
// - Power-on detector low keeps core reset
// - Enabled timer gives nominal 64 ms
// - Core held while timer still counts
// - Active-low bit enables the timer
// - Timer starts after power-on and brown-out release
// - Active detector at trip holds core
// - Two-bit field picks brown-out mode
// - Only lows beyond filter time reset
// - Always-on start waits ready and supply
// - Always-on stays active, wake not delayed
// - Mode 10 off in sleep, waits ready
// - Mode 01 follows software enable bit
// - Mode 00 off, starts immediately
// - Forced-on ready set before execution
// - Start after timer and pin release
// - Ready flag reads circuit active state
// - Software enable inert outside mode 01
package rbs_pkg;
  localparam logic [1:0] MODE_ALWAYS_ON = 2'h3;
  localparam logic [1:0] MODE_OFF_SLEEP = 2'h2;
  localparam logic [1:0] MODE_SOFTWARE = 2'h1;
  localparam logic [1:0] MODE_ALWAYS_OFF = 2'h0;
  localparam int CLK_HZ = 25000000;
  localparam int PUT_TIME_MS = 64;
  localparam int PUT_CYCLES = CLK_HZ / 1000 * PUT_TIME_MS;
  localparam int FILTER_TIME_US = 1;
  localparam int FILTER_CYCLES = (CLK_HZ / 1000000 * FILTER_TIME_US > 0) ?
    CLK_HZ / 1000000 * FILTER_TIME_US : 1;
  localparam int SLOW_DIV = 806;
  localparam logic SW_ENABLE_RESET = 1'b1;

  typedef struct packed {
    logic [1:0] brownout_mode_select;
    logic powerup_timer_enable_n;
    logic brownout_level_select;
    logic external_reset_enable;
  } rbs_config_type;

  typedef struct packed {
    logic watchdog;
    logic reset_instruction;
    logic stack_overflow;
    logic stack_underflow;
    logic program_exit;
    logic low_power_brownout;
    logic external_reset_pin_n;
  } rbs_sources_type;
endpackage : rbs_pkg

// File: rtl/rbs_counter.sv
`timescale 1ns/100ps
module rbs_counter #(
  parameter int LIMIT = 4
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_clear,
  input wire logic i_tick,
  output logic o_done
);
  import rbs_pkg::*;
  localparam int W = $clog2(LIMIT + 1);
  logic [W-1:0] count_reg;
  logic [W-1:0] count_next;
  logic done_next;

  always_comb
  begin
    count_next = count_reg;
    if (i_clear)
      count_next = '0;
    else if (i_tick && count_reg != W'(LIMIT))
      count_next = count_reg + W'(1);
    done_next = !i_clear && (count_next == W'(LIMIT));
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      count_reg <= '0;
      o_done <= 1'b0;
    end
    else
    begin
      count_reg <= count_next;
      o_done <= done_next;
    end
  end
endmodule : rbs_counter

// File: rtl/rbs_sequencer.sv
`timescale 1ns/100ps
module rbs_sequencer #(
  parameter int PUT_COUNT = rbs_pkg::PUT_CYCLES,
  parameter int SLOW_TICKS = rbs_pkg::SLOW_DIV
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire rbs_pkg::rbs_config_type i_cfg,
  input wire rbs_pkg::rbs_sources_type i_src,
  input wire logic i_supply_low_lvl0,
  input wire logic i_supply_low_lvl1,
  input wire logic i_bor_circuit_ready,
  input wire logic i_sleep,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  output logic o_core_reset,
  output logic o_brownout_ready_flag,
  output logic o_detector_enable
);
  import rbs_pkg::*;
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam int SW_EN_BIT = 7;
  localparam int READY_BIT = 0;
  localparam int PUT_TICKS = (PUT_COUNT / SLOW_TICKS > 0) ? PUT_COUNT / SLOW_TICKS : 1;
  localparam int DW = $clog2(SLOW_TICKS + 1);

  ////////////////////////////////////////////////////////////
  // Register port and brown-out mode decode
  logic sw_enable_reg;
  logic sw_enable_next;
  logic [7:0] rdata_next;
  logic bor_active;
  logic start_waits_ready;
  logic ready_flag_next;
  logic detector_next;

  always_comb
  begin
    sw_enable_next = sw_enable_reg;
    if (i_wr && i_addr == ADDR_CONTROL)
      sw_enable_next = i_wdata[SW_EN_BIT];
    rdata_next = 8'h00;
    if (i_rd && i_addr == ADDR_CONTROL)
    begin
      rdata_next[SW_EN_BIT] = sw_enable_reg;
      rdata_next[READY_BIT] = o_brownout_ready_flag;
    end
    unique case (i_cfg.brownout_mode_select)
      MODE_ALWAYS_ON: bor_active = 1'b1;
      MODE_OFF_SLEEP: bor_active = !i_sleep;
      MODE_SOFTWARE: bor_active = sw_enable_reg;
      MODE_ALWAYS_OFF: bor_active = 1'b0;
    endcase
    // Every active mode, always-on included, waits for ready before start
    start_waits_ready = bor_active && i_cfg.brownout_mode_select != MODE_ALWAYS_OFF;
    // Flag follows the circuit only while the detector is switched on
    ready_flag_next = bor_active && i_bor_circuit_ready;
    detector_next = bor_active;
  end

  ////////////////////////////////////////////////////////////
  // Brown-out filter: supply must stay low for the filter time
  logic supply_low;
  logic bor_trip;
  assign supply_low = i_cfg.brownout_level_select ? i_supply_low_lvl1 : i_supply_low_lvl0;

  rbs_counter #(.LIMIT(FILTER_CYCLES)) u_filter (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_clear(!(supply_low && bor_active && i_bor_circuit_ready)),
    .i_tick(1'b1),
    .o_done(bor_trip)
  );

  ////////////////////////////////////////////////////////////
  // Power-up timer on a slow tick, restarted by power-on or brown-out
  logic [DW-1:0] div_reg;
  logic [DW-1:0] div_next;
  logic slow_tick;
  logic put_done;
  logic put_clear;

  always_comb
  begin
    slow_tick = (div_reg == DW'(SLOW_TICKS - 1));
    div_next = slow_tick ? '0 : div_reg + DW'(1);
  end

  // Power-on is the async root; brown-out trip clears synchronously
  assign put_clear = bor_trip;

  rbs_counter #(.LIMIT(PUT_TICKS)) u_put (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_clear(put_clear),
    .i_tick(slow_tick),
    .o_done(put_done)
  );

  ////////////////////////////////////////////////////////////
  // Reset combine with synchronised release
  logic hold;
  logic put_hold;
  logic core_reset_next;
  logic ready_wait;
  logic sync_reg;
  logic sync_next;

  always_comb
  begin
    put_hold = !i_cfg.powerup_timer_enable_n && !put_done;
    ready_wait = start_waits_ready && !i_bor_circuit_ready;
    hold = bor_trip || put_hold || ready_wait
      || i_src.watchdog || i_src.reset_instruction || i_src.stack_overflow
      || i_src.stack_underflow || i_src.program_exit || i_src.low_power_brownout
      || (i_cfg.external_reset_enable && !i_src.external_reset_pin_n);
    sync_next = !hold;
    // Assert at once, release only after the second stage
    core_reset_next = hold || !sync_reg;
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      sw_enable_reg <= SW_ENABLE_RESET;
      o_rdata <= 8'h00;
      div_reg <= '0;
      sync_reg <= 1'b0;
      o_core_reset <= 1'b1;
      o_brownout_ready_flag <= 1'b0;
      o_detector_enable <= 1'b0;
    end
    else
    begin
      sw_enable_reg <= sw_enable_next;
      o_rdata <= rdata_next;
      div_reg <= div_next;
      sync_reg <= sync_next;
      o_core_reset <= core_reset_next;
      o_brownout_ready_flag <= ready_flag_next;
      o_detector_enable <= detector_next;
    end
  end

  ////////////////////////////////////////////////////////////
  // Checks
  a_trip_holds_core: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    bor_trip |=> o_core_reset)
    else $error("brown-out trip did not hold core");
  a_source_holds: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_src.watchdog |=> o_core_reset)
    else $error("watchdog did not hold core");
  a_put_holds: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (!i_cfg.powerup_timer_enable_n && !put_done) |=> o_core_reset)
    else $error("core left reset while timer counts");
  a_mode_off_inert: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (i_cfg.brownout_mode_select == MODE_ALWAYS_OFF) |=> !o_detector_enable)
    else $error("detector on in mode 00");
  a_sw_inert: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (i_cfg.brownout_mode_select == MODE_ALWAYS_ON) |=> o_detector_enable)
    else $error("software bit affected always-on mode");
  a_sleep_off: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (i_cfg.brownout_mode_select == MODE_OFF_SLEEP && i_sleep) |=> !o_detector_enable)
    else $error("detector on in sleep for mode 10");
  a_soft_ctrl: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (i_cfg.brownout_mode_select == MODE_SOFTWARE) |=> (o_detector_enable == $past(sw_enable_reg)))
    else $error("mode 01 ignores software bit");
  a_ready_flag: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    o_brownout_ready_flag |-> $past(bor_active && i_bor_circuit_ready))
    else $error("ready flag without active circuit");
  a_short_glitch: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    $rose(supply_low) |-> !bor_trip)
    else $error("trip without filter");
  a_sync_release: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    $fell(o_core_reset) |-> $past(!hold, 2) && $past(!hold))
    else $error("release not synchronised");


  ////////////////////////////////////////////////////////////
  // Further hold sources
  a_ready_wait_holds: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    ready_wait |=> o_core_reset)
    else $error("core left reset before brown-out ready");
  a_pin_holds: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (i_cfg.external_reset_enable && !i_src.external_reset_pin_n) |=> o_core_reset)
    else $error("reset pin did not hold core");
  a_low_power_brownout_holds: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_src.low_power_brownout |=> o_core_reset)
    else $error("low-power brown-out did not hold core");
  a_stack_holds: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (i_src.stack_overflow || i_src.stack_underflow) |=> o_core_reset)
    else $error("stack fault did not hold core");
  a_hold_asserts: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    hold |=> o_core_reset)
    else $error("hold did not reach core reset at once");
  a_rise_cause: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    $rose(o_core_reset) |-> $past(hold))
    else $error("core reset rose without a hold");

  ////////////////////////////////////////////////////////////
  // Timer restart and detector gating
  a_put_restart: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    bor_trip |=> !put_done)
    else $error("timer not restarted by brown-out");
  a_no_trip_off: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    !bor_active |=> !bor_trip)
    else $error("trip while detector inactive");
  a_awake_on: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (i_cfg.brownout_mode_select == MODE_OFF_SLEEP && !i_sleep) |=> o_detector_enable)
    else $error("detector off while awake in mode 10");

  ////////////////////////////////////////////////////////////
  // Register port
  a_rdata_idle: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    !i_rd |=> (o_rdata == 8'h00))
    else $error("read data outside a read");
  a_sw_readback: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (i_rd && i_addr == ADDR_CONTROL) |=> (o_rdata[SW_EN_BIT] == $past(sw_enable_reg)))
    else $error("software enable not read back");

  c_trip: cover property (@(posedge i_clk) disable iff (!i_arst_n) $rose(bor_trip));
  c_ready_wait: cover property (@(posedge i_clk) disable iff (!i_arst_n) $fell(ready_wait));
  c_sw_off: cover property (@(posedge i_clk) disable iff (!i_arst_n)
    i_cfg.brownout_mode_select == MODE_SOFTWARE && !sw_enable_reg);
  c_put_end: cover property (@(posedge i_clk) disable iff (!i_arst_n) $rose(put_done));
  c_release: cover property (@(posedge i_clk) disable iff (!i_arst_n) $fell(o_core_reset));
endmodule : rbs_sequencer

// File: sim/rbs_core_model.sv
`timescale 1ns/100ps
module rbs_core_model (
  input wire logic i_clk,
  input wire logic i_core_reset,
  output int o_run_cycles
);
  // Run count restarts on every hold, so a missed trip shows up
  always_ff @(posedge i_clk)
  begin
    o_run_cycles <= i_core_reset ? 0 : o_run_cycles + 1;
  end
endmodule : rbs_core_model

// File: sim/rbs_sequencer_test.sv
`timescale 1ns/100ps
module rbs_sequencer_test;
  import rbs_pkg::*;
  logic i_clk = 1'h0;
  logic i_arst_n = 1'h0;
  rbs_config_type cfg = '0;
  rbs_sources_type src = 7'h01;
  logic lo0 = 1'h0, lo1 = 1'h0, rdy = 1'h0, slp = 1'h0, wr = 1'h0, rd = 1'h0, r, e;
  logic [7:0] addr = 8'h00, wdata = 8'h00;
  logic [7:0] rdata;
  logic core_rst, flag, det;
  int num_errors, tests_run, cyc, run_cycles, k;
  rbs_sequencer #(.PUT_COUNT(40), .SLOW_TICKS(4)) rbs_sequencer_inst (.i_clk(i_clk), .i_arst_n(i_arst_n),
    .i_cfg(cfg), .i_src(src), .i_supply_low_lvl0(lo0), .i_supply_low_lvl1(lo1), .i_bor_circuit_ready(rdy),
    .i_sleep(slp), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .o_core_reset(core_rst), .o_brownout_ready_flag(flag), .o_detector_enable(det));
  rbs_core_model rbs_core_model_inst (.i_clk(i_clk), .i_core_reset(core_rst), .o_run_cycles(run_cycles));
  initial
  begin
    forever #20 i_clk = ~i_clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    $display("Checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : wrap_up
  task automatic chk(input string n, input logic [7:0] x, input logic [7:0] g);
    tests_run++;
    if (x !== g)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, x, g);
    end
  endtask : chk
  task automatic look(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : look
  task automatic restart(input rbs_config_type c, input logic rv);
    @(posedge i_clk);
    i_arst_n <= 1'h0;
    cfg <= c;
    rdy <= rv;
    slp <= 1'h0;
    repeat (2) @(posedge i_clk);
    i_arst_n <= 1'h1;
  endtask : restart
  // Bounded wait, k holds cycles until the core is let go
  task automatic wait_low(input int lim);
    k = 0;
    while (core_rst !== 1'h0 && k < lim)
    begin
      look(1);
      k++;
    end
  endtask : wait_low
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    @(posedge i_clk);
    wr <= 1'h0;
    rd <= 1'h0;
    #1;
  endtask : bus
  function automatic logic exp_det(input logic [1:0] m, input logic sw, input logic s);
    case (m)
      MODE_ALWAYS_ON: return 1'h1;
      MODE_OFF_SLEEP: return !s;
      MODE_SOFTWARE: return sw;
      default: return 1'h0;
    endcase
  endfunction : exp_det
  always @(posedge i_clk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      num_errors++;
      wrap_up();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(83));
    repeat (8) @(posedge i_clk);
    i_arst_n <= 1'h1;
    for (int m = 0; m < 4; m++)
      for (int v = 0; v < 4; v++)
      begin
        r = 1'($urandom % 2);
        e = exp_det(2'(m), v[0], v[1]);
        restart({2'(m), 3'h5}, r);
        slp <= v[1];
        bus(1'h1, 8'h00, {v[0], 7'h00});
        look(3);
        chk("detector", {7'h00, e}, {7'h00, det});
        chk("flag", {7'h00, e & r}, {7'h00, flag});
        bus(1'h0, 8'h00, 8'h00);
        chk("reg", {v[0], 6'h00, e & r}, rdata);
      end
    bus(1'h0, 8'h5a, 8'h00);
    chk("unmapped", 8'h00, rdata);
    $display("mode test done");
    restart(5'h05, 1'h0);
    wait_low(6);
    chk("start", 8'h00, {7'h00, core_rst});
    for (int i = 0; i < 7; i++)
    begin
      @(posedge i_clk);
      src <= 7'h01 ^ (7'h01 << i);
      look(2);
      chk("hold", 8'h01, {7'h00, core_rst});
      @(posedge i_clk);
      src <= 7'h01;
      wait_low(4);
      chk("release", 8'h00, {7'h00, core_rst});
    end
    $display("source test done");
    restart(5'h01, 1'h0);
    wait_low(2000);
    chk("timer", 8'h01, {7'h00, k >= 40 && k < 2000});
    $display("timer test done");
    restart({MODE_ALWAYS_ON, 3'h5}, 1'h0);
    look(20);
    chk("wait ready", 8'h01, {7'h00, core_rst});
    @(posedge i_clk);
    rdy <= 1'h1;
    wait_low(6);
    chk("ready start", 8'h00, {7'h00, core_rst});
    @(posedge i_clk);
    lo0 <= 1'h1;
    repeat ($urandom_range(FILTER_CYCLES - 3, 1)) @(posedge i_clk);
    lo0 <= 1'h0;
    lo1 <= 1'h1;
    look(40);
    chk("filter", 8'h00, {7'h00, core_rst});
    @(posedge i_clk);
    lo1 <= 1'h0;
    lo0 <= 1'h1;
    look(FILTER_CYCLES + 4);
    chk("trip", 8'h01, {7'h00, core_rst});
    @(posedge i_clk);
    lo0 <= 1'h0;
    wait_low(8);
    chk("rerun", 8'h01, {7'h00, run_cycles < 4});
    $display("brownout test done");
    wrap_up();
  end
endmodule : rbs_sequencer_test
